// file: hw/pri_consts.svh
// Purpose: constants of the priority interrupt controller
// Assumes: included by its bare name, definitions only
// Notes: bit positions refer to the written command byte
`ifndef PRI_CONSTS_SVH
`define PRI_CONSTS_SVH
`define PRI_LINES 8
`define PRI_ID_BIT 4
`define PRI_W4_BIT 0
`define PRI_EDGE_BIT 3
`define PRI_ADI_BIT 2
`define PRI_SNGL_BIT 1
`define PRI_SEL3_BIT 3
`define PRI_R_BIT 7
`define PRI_SL_BIT 6
`define PRI_EOI_BIT 5
`define PRI_ESMM_BIT 6
`define PRI_SMM_BIT 5
`define PRI_RR_BIT 1
`define PRI_RIS_BIT 0
`define PRI_BOTTOM_RST 3'h7
`define PRI_SPUR_LINE 3'h7
`define PRI_CALL_OP 8'hcd
`define PRI_SYNC_W 21
`endif

// file: hw/pri_ctrl.sv
// Purpose: eight-line priority interrupt controller, device side
// Assumes: asynchronous bus pins, processor gives three acknowledges
// Notes: pins pass two flops, so strobes must last over 3 cycles
`timescale 1ns/1ps
`include "pri_consts.svh"
module pri_ctrl (
   input wire logic sys_clk_in,
   input wire logic reset_n_in,
   input wire logic cs_n_in,
   input wire logic rd_n_in,
   input wire logic wr_n_in,
   input wire logic a0_in,
   input wire logic [7:0] data_in,
   input wire logic inta_n_in,
   input wire logic [7:0] request_input_in,
   output logic [7:0] data_out,
   output logic data_oe_out,
   output logic cpu_maskable_request_input_out
);
   logic [`PRI_SYNC_W-1:0] meta; // first sync stage
   logic [`PRI_SYNC_W-1:0] sync; // second sync stage
   logic cs_n_s, rd_n_s, wr_n_s, a0_s, inta_n_s;
   logic [7:0] d_s; // synced bus data
   logic [7:0] req_s; // synced request lines
   logic wr_prev, inta_prev; // edge history
   logic [7:0] req_prev; // request history
   pri_pkg::pri_init_t init_st, next_init;
   pri_pkg::pri_ack_t ack_st, next_ack;
   logic [7:0] pending_request_register, next_irr;
   logic [7:0] in_service_register, next_isr;
   logic [7:0] mask, next_mask; // one disables
   logic [2:0] bottom, next_bottom; // lowest priority line
   logic auto_rot, next_auto; // rotate at plain end
   logic smm, next_smm; // special mask mode
   logic rd_isr, next_rd_isr; // read select
   logic edge_mode, next_edge;
   logic adi, next_adi; // four-byte spacing
   logic single, next_single; // no cascade
   logic need_w4, next_need_w4;
   logic [2:0] addr75, next_addr75; // address bits 7..5
   logic [7:0] init_word_two, next_w2;
   logic [2:0] ack_line, next_ack_line;
   logic [7:0] isr_set, isr_clr, irr_clr; // update terms
   logic [3:0] top; // {valid, line} of top service
   logic hit; // resolver has a winner
   logic [2:0] line; // resolver winner
   logic wr_evt, inta_fall, inta_rise, ready;
   logic [7:0] next_data;
   logic next_oe, next_cpu_maskable_request_input;
   // assertions below share this clock and reset
   default clocking cb @(posedge sys_clk_in); endclocking
   default disable iff (!reset_n_in);

   // one-hot of a line number
   function automatic logic [7:0] one_hot(input logic [2:0] n);
      one_hot = 8'h01 << n;
   endfunction

   // highest-priority in-service line, valid bit on top
   function automatic logic [3:0] top_isr(input logic [7:0] v,
                                          input logic [2:0] b);
      logic [2:0] n;
      top_isr = 4'h0;
      n = 3'h0;
      for (int k = `PRI_LINES - 1; k >= 0; k--) begin
         n = b + 3'(k + 1);
         if (v[n]) begin
            top_isr = {1'b1, n};
         end
      end
   endfunction

   // two-flop synchroniser on every pin
   always_ff @(posedge sys_clk_in or negedge reset_n_in) begin
      if (!reset_n_in) begin
         meta <= {3'h7, 2'h1, 16'h0000};
         sync <= {3'h7, 2'h1, 16'h0000};
         wr_prev <= 1'b1;
         inta_prev <= 1'b1;
         req_prev <= 8'h00;
      end else begin
         meta <= {cs_n_in, rd_n_in, wr_n_in, a0_in, inta_n_in,
                  data_in, request_input_in};
         sync <= meta;
         wr_prev <= wr_n_s;
         inta_prev <= inta_n_s;
         req_prev <= req_s;
      end
   end

   assign {cs_n_s, rd_n_s, wr_n_s, a0_s, inta_n_s, d_s, req_s} = sync;
   // write taken at the rising write strobe
   assign wr_evt = !cs_n_s && wr_n_s && !wr_prev;
   assign inta_fall = !inta_n_s && inta_prev;
   assign inta_rise = inta_n_s && !inta_prev;
   assign ready = (init_st == pri_pkg::INI_RDY);
   assign top = top_isr(in_service_register, bottom);

   // masked requests never reach the resolver
   pri_resolve u_resolve (
      .sys_clk_in(sys_clk_in),
      .reset_n_in(reset_n_in),
      .pend_in(pending_request_register & ~mask),
      .isr_in(in_service_register),
      .bottom_in(bottom),
      .smm_in(smm),
      .hit_out(hit),
      .line_out(line)
   );

   // next state of registers, sequences and modes
   always_comb begin
      next_init = init_st;
      next_ack = ack_st;
      next_mask = mask;
      next_bottom = bottom;
      next_auto = auto_rot;
      next_smm = smm;
      next_rd_isr = rd_isr;
      next_edge = edge_mode;
      next_adi = adi;
      next_single = single;
      next_need_w4 = need_w4;
      next_addr75 = addr75;
      next_w2 = init_word_two;
      next_ack_line = ack_line;
      isr_set = 8'h00;
      isr_clr = 8'h00;
      irr_clr = 8'h00;
      // acknowledge sequence, one byte per falling edge
      case (ack_st)
         pri_pkg::ACK_IDLE: begin
            if (inta_fall) begin
               next_ack = pri_pkg::ACK_OP;
               next_ack_line = hit ? line : `PRI_SPUR_LINE;
               if (hit) begin
                  isr_set = one_hot(line);
                  irr_clr = one_hot(line);
               end
            end
         end
         pri_pkg::ACK_OP: begin
            if (inta_fall) begin
               next_ack = pri_pkg::ACK_LO;
            end
         end
         pri_pkg::ACK_LO: begin
            if (inta_fall) begin
               next_ack = pri_pkg::ACK_HI;
            end
         end
         pri_pkg::ACK_HI: begin
            if (inta_rise) begin
               next_ack = pri_pkg::ACK_IDLE;
            end
         end
         default: next_ack = pri_pkg::ACK_IDLE;
      endcase
      if (wr_evt && !a0_s) begin
         // bit 4 marks the first word
         if (d_s[`PRI_ID_BIT]) begin
            next_init = pri_pkg::INI_W2;
            next_edge = d_s[`PRI_EDGE_BIT];
            next_adi = d_s[`PRI_ADI_BIT];
            next_single = d_s[`PRI_SNGL_BIT];
            next_need_w4 = d_s[`PRI_W4_BIT];
            next_addr75 = d_s[7:5];
            next_mask = 8'h00;
            isr_clr = 8'hff;
            irr_clr = 8'hff;
            next_bottom = `PRI_BOTTOM_RST;
            next_auto = 1'b0;
            next_smm = 1'b0;
            next_rd_isr = 1'b0;
         end else if (!ready) begin
            next_init = init_st;
         end else if (!d_s[`PRI_SEL3_BIT]) begin
            if (d_s[`PRI_EOI_BIT] && !d_s[`PRI_SL_BIT]) begin
               if (top[3]) begin
                  isr_clr = one_hot(top[2:0]);
                  if (d_s[`PRI_R_BIT] || auto_rot) begin
                     next_bottom = top[2:0];
                  end
               end
               if (d_s[`PRI_R_BIT]) begin
                  next_auto = 1'b1;
               end
            end else if (d_s[`PRI_EOI_BIT]) begin
               isr_clr = one_hot(d_s[2:0]);
               next_bottom = d_s[2:0];
            end else if (d_s[`PRI_SL_BIT] && d_s[`PRI_R_BIT]) begin
               next_bottom = d_s[2:0];
            end else if (!d_s[`PRI_SL_BIT]) begin
               next_auto = d_s[`PRI_R_BIT];
            end
         end else begin
            if (d_s[`PRI_ESMM_BIT]) begin
               next_smm = d_s[`PRI_SMM_BIT];
            end
            if (d_s[`PRI_RR_BIT]) begin
               next_rd_isr = d_s[`PRI_RIS_BIT];
            end
         end
      end else if (wr_evt) begin
         case (init_st)
            pri_pkg::INI_W2: begin
               next_w2 = d_s;
               if (!single) begin
                  next_init = pri_pkg::INI_W3;
               end else if (need_w4) begin
                  next_init = pri_pkg::INI_W4;
               end else begin
                  next_init = pri_pkg::INI_RDY;
               end
            end
            pri_pkg::INI_W3: begin
               next_init = need_w4 ? pri_pkg::INI_W4 : pri_pkg::INI_RDY;
            end
            pri_pkg::INI_W4: next_init = pri_pkg::INI_RDY;
            pri_pkg::INI_RDY: next_mask = d_s;
            default: next_init = init_st;
         endcase
      end
      // pending register, set wins over clear
      if (edge_mode) begin
         next_irr = (pending_request_register & ~irr_clr) |
                    (req_s & ~req_prev);
      end else begin
         next_irr = req_s;
      end
      next_isr = (in_service_register & ~isr_clr) | isr_set;
   end

   // outputs: request, read data and acknowledge bytes
   always_comb begin
      next_data = 8'h00;
      // one request line to the processor
      next_cpu_maskable_request_input = ready && hit && (ack_st == pri_pkg::ACK_IDLE) &&
                  !inta_fall;
      next_oe = !inta_n_s || (!cs_n_s && !rd_n_s);
      if (!inta_n_s) begin
         case (next_ack)
            pri_pkg::ACK_OP: next_data = `PRI_CALL_OP;
            pri_pkg::ACK_LO: next_data = next_adi ?
               {next_addr75, next_ack_line, 2'h0} :
               {next_addr75[2:1], next_ack_line, 3'h0};
            pri_pkg::ACK_HI: next_data = next_w2;
            default: next_data = 8'h00;
         endcase
      end else if (a0_s) begin
         next_data = mask;
      end else begin
         next_data = rd_isr ? in_service_register :
                     pending_request_register;
      end
   end

   always_ff @(posedge sys_clk_in or negedge reset_n_in) begin
      if (!reset_n_in) begin
         init_st <= pri_pkg::INI_OFF;
         ack_st <= pri_pkg::ACK_IDLE;
         pending_request_register <= 8'h00;
         in_service_register <= 8'h00;
         mask <= 8'h00;
         bottom <= `PRI_BOTTOM_RST;
         auto_rot <= 1'b0;
         smm <= 1'b0;
         rd_isr <= 1'b0;
         edge_mode <= 1'b0;
         adi <= 1'b0;
         single <= 1'b1;
         need_w4 <= 1'b0;
         addr75 <= 3'h0;
         init_word_two <= 8'h00;
         ack_line <= 3'h0;
         data_out <= 8'h00;
         data_oe_out <= 1'b0;
         cpu_maskable_request_input_out <= 1'b0;
      end else begin
         init_st <= next_init;
         ack_st <= next_ack;
         pending_request_register <= next_irr;
         in_service_register <= next_isr;
         mask <= next_mask;
         bottom <= next_bottom;
         auto_rot <= next_auto;
         smm <= next_smm;
         rd_isr <= next_rd_isr;
         edge_mode <= next_edge;
         adi <= next_adi;
         single <= next_single;
         need_w4 <= next_need_w4;
         addr75 <= next_addr75;
         init_word_two <= next_w2;
         ack_line <= next_ack_line;
         data_out <= next_data;
         data_oe_out <= next_oe;
         cpu_maskable_request_input_out <= next_cpu_maskable_request_input;
      end
   end

   a_idle_uninit: assert property (!ready |=>
      !cpu_maskable_request_input_out)
      else $error("request before init");
   a_masked_quiet: assert property
      (((pending_request_register & ~mask) == 8'h00) [*2] |=>
      !cpu_maskable_request_input_out)
      else $error("masked line raised request");
   a_ack_service: assert property (inta_fall &&
      ack_st == pri_pkg::ACK_IDLE && hit |=>
      in_service_register[ack_line] && ack_st == pri_pkg::ACK_OP)
      else $error("ack did not set service");
   a_specific_end_of_service_command_clear: assert property (wr_evt && !a0_s && ready &&
      d_s[7:3] == 5'h0c |=>
      !in_service_register[$past(d_s[2:0])] &&
      bottom == $past(d_s[2:0]))
      else $error("specific end failed");
   a_auto_rotate: assert property (wr_evt && !a0_s && ready &&
      d_s == 8'ha0 && top[3] |=> bottom == $past(top[2:0]) &&
      auto_rot)
      else $error("rotation failed");
   a_first_word: assert property (wr_evt && !a0_s &&
      d_s[`PRI_ID_BIT] |=> init_st == pri_pkg::INI_W2 &&
      bottom == `PRI_BOTTOM_RST && mask == 8'h00 &&
      in_service_register == 8'h00)
      else $error("first word did not restart");
   a_vec_high: assert property (ack_st == pri_pkg::ACK_HI &&
      !inta_n_s |=> data_out == init_word_two && data_oe_out)
      else $error("high address byte wrong");
   a_level_track: assert property (!edge_mode |=>
      pending_request_register == $past(req_s))
      else $error("level request not tracked");

   c_ack_done: cover property (ack_st == pri_pkg::ACK_HI ##1
      ack_st == pri_pkg::ACK_IDLE);
   c_rotate: cover property (wr_evt && !a0_s && d_s == 8'h20 &&
      auto_rot);
   c_smm_on: cover property (!smm ##1 smm);
endmodule

// file: hw/pri_pkg.sv
// Purpose: state types of the priority interrupt controller
// Assumes: used through pri_pkg:: only
// Notes: gray codes along the usual path
package pri_pkg;
   // init sequence: off, second word, cascade word, extra word, ready
   typedef enum logic [2:0] {
      INI_OFF = 3'h0,
      INI_W2 = 3'h1,
      INI_W3 = 3'h3,
      INI_W4 = 3'h2,
      INI_RDY = 3'h6
   } pri_init_t;
   // acknowledge bytes: opcode, low address, high address
   typedef enum logic [1:0] {
      ACK_IDLE = 2'h0,
      ACK_OP = 2'h1,
      ACK_LO = 2'h3,
      ACK_HI = 2'h2
   } pri_ack_t;
endpackage

// file: hw/pri_resolve.sv
// Purpose: rotating priority resolver with registered result
// Assumes: inputs from the same clock domain
// Notes: one cycle from state change to result
`timescale 1ns/1ps
`include "pri_consts.svh"
module pri_resolve (
   input wire logic sys_clk_in,
   input wire logic reset_n_in,
   input wire logic [7:0] pend_in,
   input wire logic [7:0] isr_in,
   input wire logic [2:0] bottom_in,
   input wire logic smm_in,
   output logic hit_out,
   output logic [2:0] line_out
);
   logic next_hit; // a line wins this cycle
   logic [2:0] next_line; // winning line
   logic stop; // scan ended
   logic [2:0] ln; // line under scan

   // scan every cycle
   // scan starts one above the bottom line, wrapping
   always_comb begin
      next_hit = 1'b0;
      next_line = 3'h0;
      stop = 1'b0;
      ln = 3'h0;
      for (int k = 0; k < `PRI_LINES; k++) begin
         ln = bottom_in + 3'(k + 1);
         if (!stop) begin
            if (isr_in[ln] && !smm_in) begin
               stop = 1'b1;
            // special mask skips only that level
            end else if (pend_in[ln] && !isr_in[ln]) begin
               next_hit = 1'b1;
               next_line = ln;
               stop = 1'b1;
            end
         end
      end
   end

   // result register
   always_ff @(posedge sys_clk_in or negedge reset_n_in) begin
      if (!reset_n_in) begin
         hit_out <= 1'b0;
         line_out <= 3'h0;
      end else begin
         hit_out <= next_hit;
         line_out <= next_line;
      end
   end

   // lowest pending number wins in fixed order
   // no pending line below the winner may have been skipped
   a_fixed_top: assert property (@(posedge sys_clk_in)
      disable iff (!reset_n_in)
      (bottom_in == 3'h7 && isr_in == 8'h00 && pend_in != 8'h00)
      |=> (hit_out &&
      ($past(pend_in) & ((8'h01 << line_out) - 8'h01)) == 8'h00))
      else $error("fixed order not kept");
   // in-service line never wins itself
   // reached whenever a level line stays high during its service
   a_no_self: assert property (@(posedge sys_clk_in)
      disable iff (!reset_n_in)
      hit_out |-> ($past(isr_in) & (8'h01 << line_out)) == 8'h00)
      else $error("in-service line won again");
endmodule

// file: sim/pri_host.sv
// Purpose: host processor model for the priority interrupt controller
// Assumes: every task is entered just after a rising clock edge
// Notes: write and acknowledge strobes last five cycles, read strobes four, to cover the device's two-flop sync
`timescale 1ns/1ps
module pri_host (
   input wire logic sys_clk_in,
   input wire logic [7:0] dev_data_in,
   input wire logic dev_oe_in,
   output logic cs_n_out,
   output logic rd_n_out,
   output logic wr_n_out,
   output logic a0_out,
   output logic [7:0] data_out,
   output logic inta_n_out
);
   // idle bus at time zero, all strobes high
   initial begin
      cs_n_out = 1'b1;
      rd_n_out = 1'b1;
      wr_n_out = 1'b1;
      a0_out = 1'b0;
      data_out = 8'h00;
      inta_n_out = 1'b1;
   end

   // wait n edges, then step just past the edge
   task automatic tick(input int n);
      repeat (n) @(posedge sys_clk_in);
      #1;
   endtask

   // whole 8-bit words
   // address and data held well past the strobe rise
   task automatic wr(input logic a, input logic [7:0] d);
      cs_n_out = 1'b0;
      a0_out = a;
      data_out = d;
      wr_n_out = 1'b0;
      tick(5);
      wr_n_out = 1'b1;
      tick(5);
      cs_n_out = 1'b1;
      // released bus shows the inverse, not the old value
      data_out = ~d;
      tick(4);
   endtask

   // read: answer is due three cycles after the strobe falls
   task automatic rd(input logic a, output logic [7:0] d);
      cs_n_out = 1'b0;
      a0_out = a;
      rd_n_out = 1'b0;
      tick(4);
      // no drive from the device means no valid byte
      d = (dev_oe_in === 1'b1) ? dev_data_in : 8'hxx;
      rd_n_out = 1'b1;
      tick(4);
      cs_n_out = 1'b1;
      tick(1);
   endtask

   // three acknowledge pulses, bytes gathered high first
   task automatic ack(output logic [23:0] v);
      for (int i = 0; i < 3; i++) begin
         inta_n_out = 1'b0;
         tick(5);
         v[23 - 8 * i -: 8] = (dev_oe_in === 1'b1) ? dev_data_in : 8'hxx;
         inta_n_out = 1'b1;
         tick(5);
      end
   endtask
endmodule

// file: sim/pri_testbench.sv
// Purpose: self-checking bench for the priority interrupt controller
// Assumes: host model performs every bus and acknowledge cycle
// Notes: expected vectors are built from the init words written
`timescale 1ns/1ps
`include "pri_consts.svh"
module testbench;
   logic sys_clk_in = 1'b0; // 100 MHz system clock
   logic reset_n_in = 1'b0; // held low at start
   logic [7:0] req = 8'h00; // request lines, bench driven
   logic cs_n, rd_n, wr_n, a0, inta_n; // host strobes
   logic [7:0] hdata; // host write data
   logic [7:0] ddata; // device read data
   logic doe; // device drives bus
   logic irq; // processor request
   logic [2:0] abase; // address bits 7..5 of first word
   logic four; // four-byte spacing chosen
   logic [7:0] hi; // upper address byte
   logic [7:0] rv; // scratch read value
   logic [23:0] vv; // scratch acknowledge bytes
   int n_mismatch = 0;
   int checks = 0;

   // free-running clock
   always #5 sys_clk_in = ~sys_clk_in;

   pri_ctrl dut_u (.sys_clk_in(sys_clk_in), .reset_n_in(reset_n_in),
      .cs_n_in(cs_n), .rd_n_in(rd_n), .wr_n_in(wr_n), .a0_in(a0),
      .data_in(hdata), .inta_n_in(inta_n), .request_input_in(req),
      .data_out(ddata), .data_oe_out(doe),
      .cpu_maskable_request_input_out(irq));

   pri_host host_u (.sys_clk_in(sys_clk_in), .dev_data_in(ddata),
      .dev_oe_in(doe), .cs_n_out(cs_n), .rd_n_out(rd_n),
      .wr_n_out(wr_n), .a0_out(a0), .data_out(hdata),
      .inta_n_out(inta_n));

   // counts, verdict, end of run
   task automatic give_verdict;
      $display("checks %0d mismatches %0d", checks, n_mismatch);
      if (n_mismatch == 0 && checks > 0) begin
         $display("bench passed");
      end else begin
         $display("bench failed");
      end
      $finish;
   endtask

   // common bookkeeping of one comparison
   task automatic note(input logic ok, input string what);
      checks++;
      if (!ok) begin
         n_mismatch++;
         $display("CHECK FAILED at %0t: %s", $time, what);
      end
   endtask

   task automatic cmp_byte(input logic [7:0] got, input logic [7:0] exp);
      note(got === exp, "register byte differs");
   endtask

   task automatic cmp_vec(input logic [23:0] got, input logic [23:0] exp);
      note(got === exp, "acknowledge bytes differ");
   endtask

   // request output judged once the sync and resolver have settled
   task automatic cmp_irq(input logic exp);
      host_u.tick(8);
      note(irq === exp, "request output differs");
   endtask

   task automatic wr(input logic a, input logic [7:0] d);
      host_u.wr(a, d);
   endtask

   // select a status register, then read it back
   task automatic chk_reg(input logic [7:0] sel, input logic [7:0] exp);
      wr(1'b0, sel);
      host_u.rd(1'b0, rv);
      cmp_byte(rv, exp);
   endtask

   // expected opcode, low and high address for one line
   function automatic logic [23:0] vec(input logic [2:0] l);
      logic [7:0] lo;
      lo = four ? {abase, l, 2'b00} : {abase[2:1], l, 3'b000};
      return {`PRI_CALL_OP, lo, hi};
   endfunction

   // request must be up, then the acknowledge names the line
   task automatic serve(input logic [2:0] l);
      cmp_irq(1'b1);
      host_u.ack(vv);
      cmp_vec(vv, vec(l));
   endtask

   // two words: address fields are remembered for expectations
   task automatic init(input logic [7:0] w1, input logic [7:0] w2);
      abase = w1[7:5];
      four = w1[2];
      hi = w2;
      wr(1'b0, w1);
      wr(1'b1, w2);
   endtask

   task automatic done(input string name);
      $display("test %s finished", name);
   endtask

   // hang guard, far beyond the normal run length
   initial begin
      #200000;
      n_mismatch++;
      give_verdict();
   end

   initial begin
      repeat (5) @(posedge sys_clk_in);
      #1;
      reset_n_in = 1'b1;
      // before init the output stays idle even with a request
      cmp_irq(1'b0);
      req = 8'h01;
      cmp_irq(1'b0);
      req = 8'h00;
      done("reset");
      // level, four-byte spacing, single controller
      init(8'hb6, 8'h40);
      req = 8'h04;
      serve(3'h2);
      chk_reg(8'h0b, 8'h04);
      chk_reg(8'h0a, 8'h04);
      req = 8'h24;
      cmp_irq(1'b0);
      req = 8'h26;
      serve(3'h1);
      req = 8'h24;
      chk_reg(8'h0b, 8'h06);
      req = 8'h20;
      wr(1'b0, 8'h20);
      chk_reg(8'h0b, 8'h04);
      wr(1'b0, 8'h20);
      serve(3'h5);
      req = 8'h00;
      wr(1'b0, 8'h20);
      chk_reg(8'h0b, 8'h00);
      done("nesting");
      // per-line masks, masked service level, special mask
      wr(1'b1, 8'h04);
      host_u.rd(1'b1, rv);
      cmp_byte(rv, 8'h04);
      req = 8'h04;
      cmp_irq(1'b0);
      req = 8'h0c;
      serve(3'h3);
      req = 8'h00;
      wr(1'b1, 8'h08);
      req = 8'h40;
      cmp_irq(1'b0);
      wr(1'b0, 8'h68);
      cmp_irq(1'b1);
      wr(1'b0, 8'h48);
      cmp_irq(1'b0);
      wr(1'b0, 8'h20);
      serve(3'h6);
      req = 8'h00;
      wr(1'b0, 8'h20);
      wr(1'b1, 8'h00);
      done("mask");
      // bottom line set, specific end, auto rotation
      wr(1'b0, 8'hc4);
      req = 8'h50;
      serve(3'h6);
      cmp_irq(1'b0);
      wr(1'b0, 8'h66);
      chk_reg(8'h0b, 8'h00);
      serve(3'h4);
      wr(1'b0, 8'ha0);
      serve(3'h6);
      wr(1'b0, 8'h20);
      serve(3'h4);
      wr(1'b0, 8'h00);
      req = 8'h00;
      wr(1'b0, 8'h20);
      chk_reg(8'h0b, 8'h00);
      done("rotation");
      // edge triggered, eight-byte spacing
      init(8'hda, 8'h12);
      req = 8'h08;
      serve(3'h3);
      wr(1'b0, 8'h20);
      cmp_irq(1'b0);
      // auto mode set alone, then rotation at a plain end
      wr(1'b0, 8'h80);
      req = 8'h0a;
      serve(3'h1);
      req = 8'h08;
      wr(1'b0, 8'h20);
      // lines 1 and 2 rise together; line 1 is now bottom
      req = 8'h0e;
      serve(3'h2);
      // specific end with the rotate bit also set
      wr(1'b0, 8'he2);
      chk_reg(8'h0b, 8'h00);
      serve(3'h1);
      wr(1'b0, 8'h20);
      req = 8'h00;
      done("edge");
      give_verdict();
   end
endmodule
